/* File: common/mcg_pkg.sv */
// Constants shared by the master clock generation block
package mcg_pkg;

  // Register addresses: special function space and external data space
  localparam logic [7:0]  MCG_MCLK_CTL_ADDR      = 8'h8f;
  localparam logic [15:0] MCG_CPU_DIV_ADDR       = 16'hffa1;

  // Reset values of the two registers
  localparam logic [7:0]  MCG_MCLK_CTL_RESET     = 8'h0a;
  localparam logic [5:0]  MCG_CPU_DIV_RESET      = 6'h0c;

  // Field positions in the master clock control register
  localparam int          MCG_OSC_PLL_DIS_BIT    = 7;
  localparam int          MCG_KEYPAD_OFF_BIT     = 6;
  localparam int          MCG_CARD_OFF_BIT       = 5;
  localparam int          MCG_MULT_MSB           = 2;
  localparam int          MCG_MULT_LSB           = 0;

  // Bits that store and read back; bits 4 and 3 stay out of this mask
  localparam logic [7:0]  MCG_MCLK_CTL_WMASK     = 8'he7;

  // Field position of the processor clock divider value
  localparam int          MCG_CPU_DIV_MSB        = 5;

  // Feedback ratio of the multiplier: ratio = count * 2 + offset
  localparam logic [4:0]  MCG_RATIO_OFFSET       = 5'h04;

  // Smallest divider value that keeps the processor clock well formed
  localparam logic [5:0]  MCG_CPU_DIV_MIN        = 6'h02;

  // Target master clock and reference clock of this logic, in MHz
  localparam int          MCG_MCLK_TARGET_MHZ    = 96;
  localparam int          MCG_CLK_MHZ            = 25;

endpackage : mcg_pkg

/* File: rtl/mcg_cpu_divider.sv */
// Processor clock divider: master clock over 2 * (value + 1)
`timescale 1ns/1ns
module mcg_cpu_divider
  import mcg_pkg::*;
(
  input  wire logic       clk_i,        // Master clock
  input  wire logic       rst_n_i,      // Asynchronous reset, active low
  input  wire logic       run_i,        // Master clock is running
  input  wire logic [5:0] div_value_i,  // Divider value
  output logic            cpu_clk_o     // Divided processor clock
);

  logic [5:0] half_cnt_reg;             // Cycles into the current half period
  logic [5:0] div_used_reg;             // Divider value of this period
  logic       cpu_clk_reg;              // Output level

  // Count each half period; a half period lasts value + 1 cycles
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      half_cnt_reg <= 6'h00;
      cpu_clk_reg  <= 1'b0;
    end
    else if (!run_i)
    begin
      // Stopped master clock freezes the processor clock low
      half_cnt_reg <= 6'h00;
      cpu_clk_reg  <= 1'b0;
    end
    else if (half_cnt_reg >= div_used_reg)
    begin
      // End of a half period: toggle the output
      half_cnt_reg <= 6'h00;
      cpu_clk_reg  <= ~cpu_clk_reg;
    end
    else
    begin
      half_cnt_reg <= half_cnt_reg + 6'h01;
    end
  end

  // Take a new divider value only at a full period edge or while stopped, to avoid glitches
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_used_reg <= MCG_CPU_DIV_RESET;
    end
    else if (!run_i || (cpu_clk_reg && half_cnt_reg >= div_used_reg))
    begin
      div_used_reg <= div_value_i;
    end
  end

  assign cpu_clk_o = cpu_clk_reg;

endmodule : mcg_cpu_divider

/* File: rtl/mcg_clock_ctrl.sv */
// Master clock generation and gating control with its two registers
//
// What this block does
// - One oscillator, crystal or external clock input.
// - Divider, PLL and VCO make 96 MHz master.
// - Master clock is input times (2N + 4).
// - Control register resets to 0x0A, count 2.
// - Bit 7 set disables oscillator and PLL.
// - Bit 6 set stops the keypad clock.
// - Bit 5 set stops the card clock.
// - Processor clock defaults to 3.6923 MHz, scalable.
// - Processor clock is master over 2(div+1).
`timescale 1ns/1ns
module mcg_clock_ctrl
  import mcg_pkg::*;
(
  input  wire logic        clk_i,               // Clock, 25 MHz
  input  wire logic        rst_n_i,             // Asynchronous reset, low
  // Oscillator side
  input  wire logic        ext_clock_sel_i,     // 1 = external clock source
  // Special function register port
  input  wire logic [7:0]  sfr_addr_i,          // Register address
  input  wire logic        sfr_wr_i,            // Write strobe
  input  wire logic        sfr_rd_i,            // Read strobe
  input  wire logic [7:0]  sfr_wdata_i,         // Write data
  output logic      [7:0]  sfr_rdata_o,         // Read data, one cycle late
  output logic             sfr_hit_o,           // Read matched this block
  // External data register port
  input  wire logic [15:0] xram_addr_i,         // Register address
  input  wire logic        xram_wr_i,           // Write strobe
  input  wire logic        xram_rd_i,           // Read strobe
  input  wire logic [7:0]  xram_wdata_i,        // Write data
  output logic      [7:0]  xram_rdata_o,        // Read data, one cycle late
  output logic             xram_hit_o,          // Read matched this block
  // Analog oscillator and multiplier controls
  output logic             osc_pll_disable_o,   // Oscillator and PLL off
  output logic             osc_bypass_o,        // Oscillator amp bypassed
  output logic      [2:0]  vco_mult_select_o,   // Multiplier count
  output logic      [4:0]  vco_ratio_o,         // Feedback ratio 2N + 4
  // Peripheral clock enables
  output logic             keypad_clk_run_o,    // Keypad clock running
  output logic             card_clk_run_o,      // Card clock running
  output logic             mclk_run_o,          // Master clock running
  // Processor clock
  output logic             cpu_core_clock_o     // Divided processor clock
);

  // Register storage
  logic [7:0] master_clock_control_reg;   // Master clock control register
  logic [5:0] cpu_divider_value_reg;      // Processor clock divider value

  // Registered outputs
  logic [7:0] sfr_rdata_reg;              // Special function read data
  logic       sfr_hit_reg;                // Special function read hit
  logic [7:0] xram_rdata_reg;             // External data read data
  logic       xram_hit_reg;               // External data read hit
  logic       osc_pll_disable_reg;        // Oscillator and PLL shutdown
  logic       osc_bypass_reg;             // Oscillator bypass
  logic [2:0] vco_mult_select_reg;        // Multiplier count to the VCO
  logic [4:0] vco_ratio_reg;              // Feedback divider ratio
  logic       keypad_clk_run_reg;         // Keypad clock enable
  logic       card_clk_run_reg;           // Card clock enable
  logic       mclk_run_reg;               // Master clock enable

  // Combinational helpers
  logic       mclk_wr;                    // Write to master clock control
  logic       cpu_div_wr;                 // Write to processor divider
  logic [7:0] mclk_read_value;            // Read view of control register
  logic       cpu_clk;                    // Divider output

  // Feedback ratio of the multiplier for a given count
  function automatic logic [4:0] mult_ratio(input logic [2:0] count);
    mult_ratio = {1'b0, count, 1'b0} + MCG_RATIO_OFFSET;
  endfunction : mult_ratio

  // Address decode of the two register ports
  assign mclk_wr    = sfr_wr_i && (sfr_addr_i == MCG_MCLK_CTL_ADDR);
  assign cpu_div_wr = xram_wr_i && (xram_addr_i == MCG_CPU_DIV_ADDR);

  // Unused bits 4 and 3 always read as zero
  assign mclk_read_value =
    master_clock_control_reg & MCG_MCLK_CTL_WMASK;

  // Master clock control register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Count 2 gives 96 MHz from a 12 MHz crystal
      master_clock_control_reg <= MCG_MCLK_CTL_RESET;
    end
    else if (mclk_wr)
    begin
      // Bits 4 and 3 keep their value; writes there have no effect
      master_clock_control_reg <=
        (sfr_wdata_i & MCG_MCLK_CTL_WMASK) |
        (master_clock_control_reg & ~MCG_MCLK_CTL_WMASK);
    end
  end

  // Processor clock divider register, upper two bits read zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cpu_divider_value_reg <= MCG_CPU_DIV_RESET;
    end
    else if (cpu_div_wr)
    begin
      // Scaling of the processor clock
      cpu_divider_value_reg <=
        xram_wdata_i[MCG_CPU_DIV_MSB:0];
    end
  end

  // Special function register read path
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sfr_rdata_reg <= 8'h00;
      sfr_hit_reg   <= 1'b0;
    end
    else if (sfr_rd_i && sfr_addr_i == MCG_MCLK_CTL_ADDR)
    begin
      // Matched read returns the control register
      sfr_rdata_reg <= mclk_read_value;
      sfr_hit_reg   <= 1'b1;
    end
    else
    begin
      // Other addresses belong to other blocks; drive zero
      sfr_rdata_reg <= 8'h00;
      sfr_hit_reg   <= 1'b0;
    end
  end

  // External data register read path
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      xram_rdata_reg <= 8'h00;
      xram_hit_reg   <= 1'b0;
    end
    else if (xram_rd_i && xram_addr_i == MCG_CPU_DIV_ADDR)
    begin
      // Matched read returns the divider value, top bits zero
      xram_rdata_reg <= {2'b00, cpu_divider_value_reg};
      xram_hit_reg   <= 1'b1;
    end
    else
    begin
      // Other addresses belong to other blocks; drive zero
      xram_rdata_reg <= 8'h00;
      xram_hit_reg   <= 1'b0;
    end
  end

  // Oscillator and multiplier controls
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      osc_pll_disable_reg <= MCG_MCLK_CTL_RESET[MCG_OSC_PLL_DIS_BIT];
      osc_bypass_reg      <= 1'b0;
      vco_mult_select_reg <= MCG_MCLK_CTL_RESET[MCG_MULT_MSB:MCG_MULT_LSB];
      vco_ratio_reg       <= mult_ratio(
        MCG_MCLK_CTL_RESET[MCG_MULT_MSB:MCG_MULT_LSB]);
    end
    else
    begin
      // One oscillator; a crystal or an external clock drives it
      osc_bypass_reg      <= ext_clock_sel_i;
      // Shutdown of the oscillator together with the PLL
      osc_pll_disable_reg <=
        master_clock_control_reg[MCG_OSC_PLL_DIS_BIT];
      // Count steers the divider in the PLL feedback path
      vco_mult_select_reg <=
        master_clock_control_reg[MCG_MULT_MSB:MCG_MULT_LSB];
      // Master clock equals input frequency times 2N + 4
      vco_ratio_reg       <= mult_ratio(
        master_clock_control_reg[MCG_MULT_MSB:MCG_MULT_LSB]);
    end
  end

  // Peripheral clock gating
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mclk_run_reg       <= 1'b1;
      keypad_clk_run_reg <= 1'b1;
      card_clk_run_reg   <= 1'b1;
    end
    else
    begin
      // Without the oscillator no derived clock can run
      mclk_run_reg       <=
        !master_clock_control_reg[MCG_OSC_PLL_DIS_BIT];
      // Keypad clock stops while its off bit is set
      keypad_clk_run_reg <=
        !master_clock_control_reg[MCG_KEYPAD_OFF_BIT] &&
        !master_clock_control_reg[MCG_OSC_PLL_DIS_BIT];
      // Card clock stops while its off bit is set
      card_clk_run_reg   <=
        !master_clock_control_reg[MCG_CARD_OFF_BIT] &&
        !master_clock_control_reg[MCG_OSC_PLL_DIS_BIT];
    end
  end

  // Processor clock from the master clock
  mcg_cpu_divider u_cpu_divider (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (mclk_run_reg),
    .div_value_i (cpu_divider_value_reg),
    .cpu_clk_o   (cpu_clk)
  );

  // Output connections, all from flip-flops
  assign sfr_rdata_o       = sfr_rdata_reg;
  assign sfr_hit_o         = sfr_hit_reg;
  assign xram_rdata_o      = xram_rdata_reg;
  assign xram_hit_o        = xram_hit_reg;
  assign osc_pll_disable_o = osc_pll_disable_reg;
  assign osc_bypass_o      = osc_bypass_reg;
  assign vco_mult_select_o = vco_mult_select_reg;
  assign vco_ratio_o       = vco_ratio_reg;
  assign keypad_clk_run_o  = keypad_clk_run_reg;
  assign card_clk_run_o    = card_clk_run_reg;
  assign mclk_run_o        = mclk_run_reg;
  assign cpu_core_clock_o  = cpu_clk;

endmodule : mcg_clock_ctrl

/* File: verif/mcg_osc_source.sv */
// Model of the crystal or external clock source feeding the multiplier
`timescale 1ns/1ns
module mcg_osc_source (
  input  wire logic [2:0] row_i,      // Selected source frequency row
  output logic            ext_sel_o,  // 1 = external clock, 0 = crystal
  output logic      [2:0] count_o     // Count giving the 96 MHz master
);
  // Source table; counts stay in 1..7
  // Each row's count lands the master on 96 MHz
  always_comb
  begin
    ext_sel_o = row_i[0];    // Odd rows come from an external clock
    case (row_i)
      3'h0:    count_o = 3'h2;  // 12.00 MHz
      3'h1:    count_o = 3'h3;  // 9.60 MHz
      3'h2:    count_o = 3'h4;  // 8.00 MHz
      3'h3:    count_o = 3'h5;  // 6.86 MHz
      default: count_o = 3'h6;  // 6.00 MHz
    endcase
  end
endmodule : mcg_osc_source

/* File: verif/mcg_clock_ctrl_assertions.sv */
// Concurrent checks on the ports of the master clock control block
`timescale 1ns/1ns
module mcg_clock_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        sfr_hit_o,
  input wire logic [15:0] xram_addr_i,
  input wire logic        xram_wr_i,
  input wire logic        xram_rd_i,
  input wire logic [7:0]  xram_rdata_o,
  input wire logic        xram_hit_o,
  input wire logic        osc_pll_disable_o,
  input wire logic [2:0]  vco_mult_select_o,
  input wire logic [4:0]  vco_ratio_o,
  input wire logic        keypad_clk_run_o,
  input wire logic        card_clk_run_o,
  input wire logic        mclk_run_o,
  input wire logic        cpu_core_clock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Control register write strobe
  wire cw = sfr_wr_i && sfr_addr_i == 8'h8f;
  a_reset_count: assert property ($rose(rst_n_i) |->
    vco_ratio_o == 5'h08) else $error("multiplier not at reset count");
  a_mult_follow: assert property (cw |-> ##2
    vco_mult_select_o == $past(sfr_wdata_i[2:0], 2))
    else $error("multiplier count not taken");
  a_ratio_calc: assert property (vco_ratio_o ==
    {1'b0, vco_mult_select_o, 1'b0} + 5'h04) else $error("bad ratio");
  a_osc_off: assert property (cw |-> ##2
    osc_pll_disable_o == $past(sfr_wdata_i[7], 2)) else $error("osc bit");
  a_master_stop: assert property (mclk_run_o == !osc_pll_disable_o)
    else $error("master run wrong");
  a_keypad_gate: assert property (cw |-> ##2 keypad_clk_run_o ==
    !($past(sfr_wdata_i[6], 2) || $past(sfr_wdata_i[7], 2)))
    else $error("keypad gate wrong");
  a_card_gate: assert property (cw |-> ##2 card_clk_run_o ==
    !($past(sfr_wdata_i[5], 2) || $past(sfr_wdata_i[7], 2)))
    else $error("card gate wrong");
  a_cpu_hold: assert property (!mclk_run_o [*2] |->
    !cpu_core_clock_o) else $error("cpu clock runs while stopped");
  a_unused_zero: assert property (sfr_rdata_o[4:3] == 2'b00)
    else $error("unused bits read back set");
  a_write_read: assert property (cw ##1
    (sfr_rd_i && sfr_addr_i == 8'h8f) |=>
    sfr_hit_o && sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'he7))
    else $error("readback differs from write");
  a_div_read: assert property (xram_rd_i &&
    xram_addr_i == 16'hffa1 |=> xram_hit_o && xram_rdata_o[7:6] == 2'b00)
    else $error("divider read");
  // Main scenarios reached
  c_osc_off: cover property (cw && sfr_wdata_i[7]);
  c_cpu_rise: cover property ($rose(cpu_core_clock_o));
  c_div_write: cover property (xram_wr_i && xram_addr_i == 16'hffa1);
endmodule : mcg_clock_ctrl_checker
bind mcg_clock_ctrl mcg_clock_ctrl_checker u_chk (.*);

/* File: verif/test_mcg_clock_ctrl.sv */
// Self-checking bench for the master clock control block
`timescale 1ns/1ns
module test_mcg_clock_ctrl;
  logic clk_i, rst_n_i, ext_clock_sel_i, sfr_wr_i, sfr_rd_i;
  logic xram_wr_i, xram_rd_i, sfr_hit_o, xram_hit_o, osc_pll_disable_o;
  logic osc_bypass_o, keypad_clk_run_o, card_clk_run_o, mclk_run_o;
  logic cpu_core_clock_o, h;
  logic [7:0] sfr_addr_i, sfr_wdata_i, xram_wdata_i, sfr_rdata_o;
  logic [7:0] xram_rdata_o, d, v;
  logic [15:0] xram_addr_i;
  logic [2:0] vco_mult_select_o, row, cnt;
  logic [4:0] vco_ratio_o;
  logic [31:0] seed;
  int failures, cmp_count, n;
  mcg_clock_ctrl DUT (.*);
  mcg_osc_source u_src (.row_i(row), .ext_sel_o(ext_clock_sel_i),
    .count_o(cnt));
  // Free running 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  // One register write, entered at a falling edge; sp = 1 picks sfr port
  // Strobes stay up; the next transfer or idle sets them once per edge
  task automatic wr(input logic sp, input logic [15:0] a,
                    input logic [7:0] w);
    sfr_addr_i = a[7:0];
    xram_addr_i = a;
    sfr_wdata_i = w;
    xram_wdata_i = w;
    {sfr_wr_i, xram_wr_i, sfr_rd_i, xram_rd_i} = {sp, !sp, 2'b00};
    @(negedge clk_i);
  endtask : wr
  // One register read; data and hit sampled one cycle after the strobe
  task automatic rd(input logic sp, input logic [15:0] a, output logic [7:0] r,
                    output logic hit);
    sfr_addr_i = a[7:0];
    xram_addr_i = a;
    {sfr_wr_i, xram_wr_i, sfr_rd_i, xram_rd_i} = {2'b00, sp, !sp};
    @(negedge clk_i);
    r = sp ? sfr_rdata_o : xram_rdata_o;
    hit = sp ? sfr_hit_o : xram_hit_o;
  endtask : rd
  // Drops every strobe, then lets k falling edges pass
  task automatic idle(input int k);
    {sfr_wr_i, xram_wr_i, sfr_rd_i, xram_rd_i} = 4'h0;
    repeat (k) @(negedge clk_i);
  endtask : idle
  // Waits for the next rise of the cpu clock, counting cycles, bounded
  task automatic rise(inout int c);
    int k;
    k = 0;
    while (cpu_core_clock_o !== 1'b0 && k < 300)
    begin
      @(negedge clk_i);
      k++;
    end
    while (cpu_core_clock_o !== 1'b1 && k < 300)
    begin
      @(negedge clk_i);
      k++;
    end
    c += k;
    if (k >= 300)
    begin
      failures++;
      tally_and_finish;
    end
  endtask : rise
  task automatic period(input int exp);
    int c;
    idle(0);
    c = 0;
    rise(c);
    rise(c);
    c = 0;
    rise(c);
    chk(c[7:0], exp[7:0]);
  endtask : period
  // Main sequence
  initial
  begin
    {rst_n_i, sfr_wr_i, sfr_rd_i, xram_wr_i, xram_rd_i} = 5'h00;
    {sfr_addr_i, sfr_wdata_i, xram_wdata_i, xram_addr_i} = 40'h0;
    row = 3'h0;
    seed = 32'h5dd0_b3e5;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(1'b1, 16'h008f, d, h);
    chk(d, 8'h02);
    chk1(h, 1'b1);
    chk({3'h0, vco_ratio_o}, 8'h08);
    rd(1'b0, 16'hffa1, d, h);
    chk(d, 8'h0c);
    period(26);
    // Source rows 0 to 4, their counts and the resulting ratios
    for (n = 0; n < 5; n++)
    begin
      // Let the source model settle on the new row before using its count
      row = n[2:0];
      idle(1);
      wr(1'b1, 16'h008f, {5'h00, cnt});
      idle(2);
      chk({5'h0, vco_mult_select_o}, {5'h0, cnt});
      chk({3'h0, vco_ratio_o}, {4'h0, cnt, 1'b0} + 8'h04);
      chk1(osc_bypass_o, row[0]);
    end
    // Random gating patterns, back-to-back write and read
    for (n = 0; n < 24; n++)
    begin
      seed = lfsr(seed);
      // Oscillator bit kept clear, count kept at the 96 MHz value
      v = {1'b0, seed[14:11], cnt};
      wr(1'b1, 16'h008f, v);
      rd(1'b1, 16'h008f, d, h);
      chk(d, v & 8'he7);
      idle(1);
      chk1(keypad_clk_run_o, !v[6]);
      chk1(card_clk_run_o, !v[5]);
    end
    // Oscillator and PLL shut down, then restored
    wr(1'b1, 16'h008f, 8'h82);
    idle(2);
    chk({4'h0, osc_pll_disable_o, mclk_run_o, keypad_clk_run_o,
         card_clk_run_o}, 8'h08);
    d = 8'h00;
    repeat (40)
    begin
      @(negedge clk_i);
      d[0] = d[0] | cpu_core_clock_o;
    end
    chk(d, 8'h00);
    wr(1'b1, 16'h008e, 8'hff);
    rd(1'b1, 16'h008e, d, h);
    chk(d, 8'h00);
    chk1(h, 1'b0);
    wr(1'b1, 16'h008f, {5'h00, cnt});
    // Divider corners and random values
    for (n = 0; n < 4; n++)
    begin
      seed = lfsr(seed);
      v = (n == 0) ? 8'h02 : (n == 1) ? 8'h3f : 8'h02 + 8'(seed % 62);
      wr(1'b0, 16'hffa1, v);
      rd(1'b0, 16'hffa2, d, h);
      chk(d, 8'h00);
      chk1(h, 1'b0);
      rd(1'b0, 16'hffa1, d, h);
      chk(d, v);
      chk1(h, 1'b1);
      period(2 * (int'(v) + 1));
    end
    tally_and_finish;
  end
endmodule : test_mcg_clock_ctrl
